// >>> core/scr_readout.sv
// Serial configuration memory readout: stream, clocking, cascade and pin control
`timescale 1ns/100ps

// How it works
// - Reset level on output-enable pin clears address and floats data.
// - Chip select high after reset keeps counter stopped and data floating.
// - Chip select low with output enabled starts counting and drives data.
// - Any new reset level clears and floats regardless of chip select.
// - After the last bit with cascade low, data output floats.
// - Power-up reset clears the address counter by itself.
// - Each rising config clock advances the address while enabled, selected, data left.
// - A clock master drives config clock low outside the run, done and tail phases and in reset, and floats it in programming mode.
// - In master mode the reset level stops the oscillator, clock low.
// - Chip select seen during reset picks master or chained follower role.
// - The first device clocks the target and followers until transfer completes.
// - Cascade output goes low once the address reaches its maximum.
// - After chip select rises, master gives 16 more clocks then sleeps.
// - Chip select rising before the end flags a configuration error in master mode.
// - A stored configuration byte selects the reset pin polarity.
// - Ready output held low through power-up, released afterwards.
// - Program select low switches to two-wire programming.
// - In programming mode the device-select bit decides whether writes apply.
// - Write protect blocks writes to the protected memory region.
module scr_readout #(
   parameter int DEPTH = scr_pkg::MEM_DEPTH,
   parameter int PROT_START = scr_pkg::PROT_BASE,
   parameter int CLK_HALF = scr_pkg::CFG_CLK_HALF,
   parameter int PWR_CYC = scr_pkg::POWERUP_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic linkClk,
   input wire logic oeResetPin,
   input wire logic chip_select_n,
   input wire logic serial_program_select,
   input wire logic device_select_bit,
   input wire logic write_protect_in,
   input wire logic [7:0] polarityByte,
   input wire scr_pkg::scr_wr_t wrReq,
   output logic config_clock,
   output logic configClockOe,
   output logic target_serial_in,
   output logic serialDataOe,
   output logic cascade_out_n,
   output logic readyOut,
   output logic readyOe,
   output logic configError,
   output logic isMaster
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] ADDR_MAX = AW'(DEPTH - 1);
   localparam logic [AW-1:0] PROT_ADDR = AW'(PROT_START);
   localparam logic [7:0] HALF_LAST = 8'(CLK_HALF - 1);
   localparam logic [4:0] TAIL_LAST = 5'(scr_pkg::TAIL_CLKS - 1);
   localparam logic [15:0] PWR_LAST = 16'(PWR_CYC - 1);

   // ==========================================================
   // Elaboration checks; refused before any logic is built
   if (DEPTH < 2 || AW > 20) begin
      $error("DEPTH must lie between 2 and 2**20");
   end
   if (CLK_HALF < 1 || CLK_HALF > 255) begin
      $error("CLK_HALF must lie between 1 and 255");
   end
   if (PWR_CYC < 1 || PWR_CYC > 65535) begin
      $error("PWR_CYC must lie between 1 and 65535");
   end

   // ==========================================================
   // Link domain: each rising config clock flips a toggle
   logic linkTgl_ff;

   // Toggle survives a stopped clock; only its edges are events
   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         linkTgl_ff <= 1'b0;
      end else begin
         linkTgl_ff <= ~linkTgl_ff;
      end
   end

   // ==========================================================
   // Pin synchronisation
   scr_pkg::scr_ctl_t rawCtl;
   scr_pkg::scr_ctl_t ctl;

   assign rawCtl = '{oeRst: oeResetPin, csN: chip_select_n, progSel: serial_program_select,
                     devSel: device_select_bit, wprot: write_protect_in, linkTgl: linkTgl_ff};

   scr_sync #(.W($bits(scr_pkg::scr_ctl_t))) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .din(rawCtl),
      .dout(ctl)
   );

   // ==========================================================
   // State
   scr_pkg::scr_state_t state_ff;
   scr_pkg::scr_state_t nxt_state;
   logic [AW-1:0] addr_ff;
   logic allSent_ff;
   logic roleMaster_ff;
   logic [7:0] divCnt_ff;
   logic clkOut_ff;
   logic [4:0] tailCnt_ff;
   logic [15:0] pwrCnt_ff;
   logic pwrDone_ff;
   logic tglSeen_ff;
   logic dataBit_ff;
   logic dataOe_ff;
   logic casc_ff;
   logic err_ff;
   logic mem [DEPTH];

   // ==========================================================
   // Decode of pin levels
   wire oeHigh = polarityByte[scr_pkg::POL_BIT] ? ~ctl.oeRst : ctl.oeRst;
   wire inReset = ~oeHigh;
   wire progMode = ~ctl.progSel;
   wire selected = ~ctl.csN;
   wire inRun = (state_ff == scr_pkg::ST_RUN);
   wire inDone = (state_ff == scr_pkg::ST_DONE);
   wire inTail = (state_ff == scr_pkg::ST_TAIL);

   // Counting needs output enabled, selection and data left
   wire countOk = oeHigh & selected & ~allSent_ff & ~progMode & inRun;

   // Master keeps clocking followers after its own data, and the tail
   wire clkRun = roleMaster_ff & oeHigh & ~progMode &
                 ((selected & (inRun | inDone)) | inTail);

   wire divWrap = (divCnt_ff == HALF_LAST);
   wire masterRise = clkRun & divWrap & ~clkOut_ff;
   wire slaveRise = ctl.linkTgl ^ tglSeen_ff;
   wire tick = roleMaster_ff ? masterRise : slaveRise;
   wire advance = tick & countOk;
   wire lastBit = advance & (addr_ff == ADDR_MAX);
   wire earlyRise = roleMaster_ff & inRun & ~selected & oeHigh & ~progMode;

   // Writes only in programming mode, to this device, outside protection
   wire protHit = ctl.wprot & (wrReq.addr[AW-1:0] >= PROT_ADDR);
   wire wrOk = wrReq.en & progMode & (ctl.devSel == scr_pkg::DEV_SEL_MATCH) & ~protHit;

   // ==========================================================
   // Sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         scr_pkg::ST_IDLE: begin
            if (pwrDone_ff && oeHigh && !progMode && selected) begin
               nxt_state = scr_pkg::ST_RUN;
            end
         end
         scr_pkg::ST_RUN: begin
            if (lastBit) begin
               nxt_state = scr_pkg::ST_DONE;
            end else if (earlyRise) begin
               nxt_state = scr_pkg::ST_SLEEP;
            end else if (!selected) begin
               nxt_state = scr_pkg::ST_IDLE;
            end
         end
         scr_pkg::ST_DONE: begin
            if (roleMaster_ff && !selected) begin
               nxt_state = scr_pkg::ST_TAIL;
            end
         end
         scr_pkg::ST_TAIL: begin
            if (masterRise && tailCnt_ff == TAIL_LAST) begin
               nxt_state = scr_pkg::ST_SLEEP;
            end
         end
         scr_pkg::ST_SLEEP: begin
            nxt_state = scr_pkg::ST_SLEEP;
         end
         default: begin
            nxt_state = scr_pkg::ST_IDLE;
         end
      endcase
      if (inReset) begin
         nxt_state = scr_pkg::ST_IDLE;
      end else if (progMode) begin
         nxt_state = scr_pkg::ST_IDLE;
      end
   end

   // ==========================================================
   // Sequencer, address counter and role
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_ff <= scr_pkg::ST_IDLE;
         addr_ff <= '0;
         allSent_ff <= 1'b0;
         roleMaster_ff <= 1'b0;
         tglSeen_ff <= 1'b0;
         err_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         tglSeen_ff <= ctl.linkTgl;
         if (inReset) begin
            addr_ff <= '0;
            allSent_ff <= 1'b0;
            roleMaster_ff <= selected;
            err_ff <= 1'b0;
         end else if (advance) begin
            addr_ff <= lastBit ? addr_ff : addr_ff + 1'b1;
            allSent_ff <= lastBit;
         end
         if (earlyRise) begin
            err_ff <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Oscillator divider and tail count
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         divCnt_ff <= '0;
         clkOut_ff <= 1'b0;
         tailCnt_ff <= '0;
      end else if (ce) begin
         if (!clkRun) begin
            divCnt_ff <= '0;
            clkOut_ff <= 1'b0;
         end else if (divWrap) begin
            divCnt_ff <= '0;
            clkOut_ff <= ~clkOut_ff;
         end else begin
            divCnt_ff <= divCnt_ff + 8'h01;
         end
         if (!inTail) begin
            tailCnt_ff <= '0;
         end else if (masterRise) begin
            tailCnt_ff <= tailCnt_ff + 5'h01;
         end
      end
   end

   // ==========================================================
   // Power-up ready timer
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pwrCnt_ff <= '0;
         pwrDone_ff <= 1'b0;
      end else if (ce && !pwrDone_ff) begin
         pwrCnt_ff <= pwrCnt_ff + 16'h0001;
         pwrDone_ff <= (pwrCnt_ff == PWR_LAST);
      end
   end

   // ==========================================================
   // Output flops; data lags the address by one system cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dataBit_ff <= 1'b0;
         dataOe_ff <= 1'b0;
         casc_ff <= 1'b1;
      end else if (ce) begin
         dataBit_ff <= mem[addr_ff];
         dataOe_ff <= countOk & ~lastBit;
         casc_ff <= ~(allSent_ff | lastBit) | inReset;
      end
   end

   // Memory array has no reset; contents come from programming
   always_ff @(posedge clk_sys) begin
      if (ce && wrOk) begin
         mem[wrReq.addr[AW-1:0]] <= wrReq.data;
      end
   end

   // ==========================================================
   // Pin drives
   assign config_clock = clkOut_ff;
   assign configClockOe = roleMaster_ff & ~progMode;
   assign target_serial_in = dataBit_ff;
   assign serialDataOe = dataOe_ff;
   assign cascade_out_n = casc_ff;
   assign readyOut = 1'b0;
   assign readyOe = ~pwrDone_ff;
   assign configError = err_ff;
   assign isMaster = roleMaster_ff;

   // ==========================================================
   // Checks
   rst_float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && inReset |=> !serialDataOe && addr_ff == '0)
      else $error("reset level did not clear and float");

   desel_float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && !selected |=> !serialDataOe)
      else $error("data driven while deselected");

   cnt_enable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && countOk && !lastBit |=> serialDataOe)
      else $error("data not driven while counting");

   reset_any_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && $fell(oeHigh) |=> state_ff == scr_pkg::ST_IDLE)
      else $error("new reset level ignored");

   end_float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !cascade_out_n |-> !serialDataOe)
      else $error("data driven after cascade handoff");

   adv_one_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && advance && !lastBit |=> addr_ff == $past(addr_ff) + 1'b1)
      else $error("address did not advance by one");

   mclk_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && roleMaster_ff && !clkRun |=> !config_clock)
      else $error("master clock not low while stopped");

   osc_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && inReset ##1 ce && inReset |=> !config_clock && divCnt_ff == '0)
      else $error("oscillator running in reset");

   role_sample_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && inReset |=> isMaster == $past(selected))
      else $error("role not taken from chip select");

   casc_max_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && lastBit |=> !cascade_out_n && allSent_ff)
      else $error("cascade not asserted at maximum");

   tail_sixteen_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && inTail && masterRise && tailCnt_ff == TAIL_LAST && oeHigh && !progMode
      |=> state_ff == scr_pkg::ST_SLEEP)
      else $error("tail clocks miscounted");

   early_err_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && earlyRise && !lastBit |=> configError && state_ff == scr_pkg::ST_SLEEP)
      else $error("early deselect not flagged");

   ready_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !pwrDone_ff |-> readyOe && !readyOut)
      else $error("ready released during power-up");

   prot_block_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      protHit || !progMode |-> !wrOk)
      else $error("write reached protected or readout memory");

   prog_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && progMode |=> !serialDataOe && !config_clock)
      else $error("readout active in programming mode");

endmodule

// >>> core/scr_sync.sv
// Two-flop synchroniser for a vector of unrelated levels
`timescale 1ns/100ps

module scr_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;

   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s1_ff <= '0;
         s2_ff <= '0;
      end else if (ce) begin
         s1_ff <= din;
         s2_ff <= s1_ff;
      end
   end

   assign dout = s2_ff;

endmodule

// >>> include/scr_pkg.sv
// Shared constants and carrier types for the serial configuration readout
package scr_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int POWERUP_NS = 1000;
   localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CFG_CLK_HALF = 2;
   localparam int TAIL_CLKS = 16;

   // ==========================================================
   // Memory and selection defaults
   localparam int MEM_DEPTH = 1048576;
   localparam int PROT_BASE = 983040;
   localparam logic DEV_SEL_MATCH = 1'b0;
   localparam int POL_BIT = 0;

   // ==========================================================
   // Readout sequencer states
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_RUN   = 5'h02,
      ST_DONE  = 5'h04,
      ST_TAIL  = 5'h08,
      ST_SLEEP = 5'h10
   } scr_state_t;

   // Pin-level controls after synchronising
   typedef struct packed {
      logic oeRst;
      logic csN;
      logic progSel;
      logic devSel;
      logic wprot;
      logic linkTgl;
   } scr_ctl_t;

   // Bit write from the programming logic
   typedef struct packed {
      logic en;
      logic [19:0] addr;
      logic data;
   } scr_wr_t;

endpackage

// >>> tb/scr_target_model.sv
// Target array model: takes the serial stream and raises done when full
`timescale 1ns/100ps
module scr_target_model (
   input wire logic cfgClk,
   input wire logic dataDrv,
   input wire logic dataOe,
   input wire logic clrRx,
   input wire logic armDone,
   output logic dataWire,
   output logic [15:0] rxBits,
   output int rxCnt,
   output logic doneOut
);
   logic lastBit = 1'b0;
   logic oeSeen;
   logic bitSeen;
   // A released line shows the inverse of the last bit, never a stale copy
   assign dataWire = dataOe ? dataDrv : ~lastBit;
   always @(dataDrv or dataOe) if (dataOe) lastBit = dataDrv;
   // Line as it stood just before the edge: a master moves its data
   // flops in the very time step that raises its clock
   assign #1 oeSeen = dataOe;
   assign #1 bitSeen = dataWire;
   // Only driven bits are taken, the first one lands in slot 0
   always @(posedge cfgClk or posedge clrRx) begin
      if (clrRx) begin
         rxCnt <= 0;
         rxBits <= 16'h0000;
      end else if (oeSeen && rxCnt < 16) begin
         rxBits[rxCnt] <= bitSeen;
         rxCnt <= rxCnt + 1;
      end
   end
   // Done lifts the first device's chip select once all bits are in
   assign doneOut = armDone && (rxCnt == 16);
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the serial configuration readout
`timescale 1ns/100ps
module tb_top;
   localparam int DEPTH = 16;
   localparam logic [15:0] PAT = 16'hA5C3;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic linkClk = 1'b0;
   logic linkRun = 1'b0;
   logic oeResetPin = 1'b0;
   logic csDrv = 1'b0;
   logic progSel = 1'b0;
   logic devSel = 1'b0;
   logic wProt = 1'b0;
   logic [7:0] polByte = 8'h00;
   scr_pkg::scr_wr_t wrReq = '0;
   logic clrRx = 1'b1;
   logic armDone = 1'b0;
   logic cfgClkOut, cfgClkOe, dataOut, dataOe, cascN, readyOut, readyOe, cfgErr, isMaster;
   logic dataWire, tgtDone, cfgWire, chipSelN;
   logic [15:0] rxBits;
   int rxCnt;
   int mismatches = 0;
   int nChecks = 0;
   int cycles = 0;
   int n;
   // ==========================================================
   // Pins and clocks
   assign cfgWire = cfgClkOe ? cfgClkOut : linkClk;
   assign chipSelN = csDrv | tgtDone;
   always #10 clk_sys = ~clk_sys;
   // Link clock stands still outside frames
   initial #7 forever #62.5 linkClk = linkRun ? ~linkClk : 1'b0;
   scr_readout #(.DEPTH(DEPTH), .PROT_START(12), .CLK_HALF(2), .PWR_CYC(4)) uut (
      .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .linkClk(cfgWire),
      .oeResetPin(oeResetPin), .chip_select_n(chipSelN), .serial_program_select(progSel),
      .device_select_bit(devSel), .write_protect_in(wProt), .polarityByte(polByte),
      .wrReq(wrReq), .config_clock(cfgClkOut), .configClockOe(cfgClkOe),
      .target_serial_in(dataOut), .serialDataOe(dataOe), .cascade_out_n(cascN),
      .readyOut(readyOut), .readyOe(readyOe), .configError(cfgErr), .isMaster(isMaster));
   scr_target_model tgt (.cfgClk(cfgWire), .dataDrv(dataOut), .dataOe(dataOe),
      .clrRx(clrRx), .armDone(armDone), .dataWire(dataWire), .rxBits(rxBits),
      .rxCnt(rxCnt), .doneOut(tgtDone));
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && nChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   // Writes every address once; refused writes leave the old bit
   task automatic fill(input logic [15:0] v);
      cyc(4);
      for (int i = 0; i < DEPTH; i++) begin
         wrReq <= '{1'b1, 20'(i), v[i]};
         @(posedge clk_sys);
      end
      wrReq <= '0;
   endtask
   // Counts config clock rises, sampled where the register has settled
   task automatic rises(input int k, output int cnt);
      logic prev;
      prev = cfgClkOut;
      cnt = 0;
      repeat (k) begin
         @(negedge clk_sys);
         if (cfgClkOut && !prev) cnt++;
         prev = cfgClkOut;
      end
      @(posedge clk_sys);
   endtask
   // Reset level on the enable pin; chip select meanwhile picks the role
   task automatic rstLevel(input logic cs);
      @(posedge clk_sys);
      oeResetPin <= polByte[0];
      csDrv <= cs;
      clrRx <= 1'b1;
      cyc(6);
      oeResetPin <= ~polByte[0];
      clrRx <= 1'b0;
   endtask
   task automatic waitCasc();
      for (int i = 0; i < 600 && cascN !== 1'b0; i++) @(negedge clk_sys);
      @(negedge clk_sys);
      @(negedge clk_sys);
   endtask
   // Cuts a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         give_verdict();
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      cyc(10);
      nrst <= 1'b1;
      oeResetPin <= 1'b1;
      @(negedge clk_sys);
      chk("readyOe", 1'b1, readyOe);
      chk("readyOut", 1'b0, readyOut);
      chk("dataOe", 1'b0, dataOe);
      cyc(10);
      chk("readyOe", 1'b0, readyOe);
      fill(PAT);
      wProt <= 1'b1;
      fill(~PAT);
      wProt <= 1'b0;
      devSel <= 1'b1;
      fill(PAT);
      devSel <= 1'b0;
      @(negedge clk_sys);
      chk("progClk", 1'b0, cfgClkOut);
      chk("progData", 1'b0, dataOe);
      // Master readout of the whole store, then the follower phase
      @(posedge clk_sys);
      progSel <= 1'b1;
      rstLevel(1'b0);
      waitCasc();
      chk("isMaster", 1'b1, isMaster);
      chk("masterClkOe", 1'b1, cfgClkOe);
      chk("cascN", 1'b0, cascN);
      chk("rxCnt", DEPTH, rxCnt);
      chk("rxBits", {PAT[15:12], ~PAT[11:0]}, rxBits);
      chk("lastData", 1'b0, dataOe);
      rises(20, n);
      chk("followClk", 1'b1, n >= 4);
      armDone <= 1'b1;
      rises(200, n);
      chk("tailClk", 1'b1, n == 16 || n == 17);
      chk("sleepClk", 1'b0, cfgClkOut);
      chk("noErr", 1'b0, cfgErr);
      // Early deselect, then a reset level with chip select low
      armDone <= 1'b0;
      rstLevel(1'b0);
      cyc(20);
      csDrv <= 1'b1;
      cyc(6);
      chk("cfgErr", 1'b1, cfgErr);
      csDrv <= 1'b0;
      oeResetPin <= 1'b0;
      cyc(6);
      @(negedge clk_sys);
      chk("rstClk", 1'b0, cfgClkOut);
      chk("rstData", 1'b0, dataOe);
      chk("errClr", 1'b0, cfgErr);
      // Follower role clocked from the link side
      rstLevel(1'b1);
      linkRun <= 1'b1;
      cyc(40);
      chk("slave", 1'b0, isMaster);
      chk("slaveClkOe", 1'b0, cfgClkOe);
      chk("deselData", 1'b0, dataOe);
      chk("deselCasc", 1'b1, cascN);
      csDrv <= 1'b0;
      cyc(12);
      chk("selData", 1'b1, dataOe);
      waitCasc();
      chk("slaveCasc", 1'b0, cascN);
      chk("slaveFloat", 1'b0, dataOe);
      // Inverted reset polarity
      @(posedge clk_sys);
      linkRun <= 1'b0;
      polByte <= 8'h01;
      rstLevel(1'b0);
      cyc(30);
      chk("polRun", 1'b1, dataOe);
      oeResetPin <= 1'b1;
      cyc(6);
      chk("polRst", 1'b0, dataOe);
      give_verdict();
   end
endmodule
